// *** logic/cassr_regs.sv ***
/*
 * Status register bank for the authentication and short-message groups:
 * condition, transition filters, sticky event latch and enable mask for
 * each, plus a summary output per group toward the status byte path.
 * A command carries a group (0 auth, 1 short message) and a selector
 * (0 condition, 1 rise filter, 2 fall filter, 3 event latch, 4 enable
 * mask); selectors 5 to 7 read as zero and ignore writes, and writes to
 * the condition or the event latch are ignored as well.
 * A query is answered on resp one cycle later for exactly one cycle, with
 * the value held before any write taken in the same cycle; reading the
 * event latch returns its contents and clears it.
 * Transition filters act only on bits that have a live condition source;
 * event-only bits latch straight from their pulse inputs.
 * The group summaries lag a latch or mask change by one cycle.
 * Assumes condition and event inputs are synchronous to ref_clk and that
 * commands arrive as one-cycle strobes from the remote command decoder.
 * Assumes WIDTH stays at the package register width, since the reset
 * values and bit masks are declared at that width.
 */
`timescale 1ns/1ps
module cassr_regs
    import cassr_pkg::*;
#(
    parameter int unsigned WIDTH = REG_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire cassr_cmd_t cmd,
    input wire logic clear_status,
    input wire logic auth_in_progress,
    input wire logic auth_secret_update_busy,
    input wire logic auth_challenge_busy,
    input wire logic shared_secret_a_value_zero,
    input wire logic auth_reg_passed,
    input wire logic auth_page_passed,
    input wire logic auth_orig_passed,
    input wire logic auth_chal_passed,
    input wire logic auth_update_passed,
    input wire logic auth_burst_result,
    input wire logic sms_in_progress,
    input wire logic sms_ack_received,
    input wire logic general_group_summary,
    input wire logic general_summary_enable,
    output cassr_resp_t resp,
    output logic auth_group_summary_bit,
    output logic sms_group_summary_bit,
    output logic general_summary_to_status_byte
);
    localparam int unsigned NGRP = 2;

    logic [WIDTH-1:0] cond [NGRP];
    logic [WIDTH-1:0] cond_q [NGRP];
    logic [WIDTH-1:0] evt_in [NGRP];
    logic [WIDTH-1:0] rise_filter [NGRP];
    logic [WIDTH-1:0] fall_filter [NGRP];
    logic [WIDTH-1:0] event_latch [NGRP];
    logic [WIDTH-1:0] event_mask [NGRP];
    logic [WIDTH-1:0] read_mux [NGRP];
    logic [NGRP-1:0] summary;

    // live condition levels; unbacked bits stay zero
    always_comb begin
        cond[GRP_AUTH] = '0;
        cond[GRP_AUTH][AUTH_IN_PROGRESS_BIT] = auth_in_progress;
        cond[GRP_AUTH][AUTH_SECRET_UPDATE_BIT] = auth_secret_update_busy;
        cond[GRP_AUTH][AUTH_CHALLENGE_BIT] = auth_challenge_busy;
        cond[GRP_AUTH][AUTH_SECRET_ZERO_BIT] = shared_secret_a_value_zero;
        cond[GRP_SMS] = '0;
        cond[GRP_SMS][SMS_IN_PROGRESS_BIT] = sms_in_progress;
    end

    // event-only pulses bypass the transition filters
    always_comb begin
        evt_in[GRP_AUTH] = '0;
        evt_in[GRP_AUTH][AUTH_REG_PASSED_BIT] = auth_reg_passed;
        evt_in[GRP_AUTH][AUTH_PAGE_PASSED_BIT] = auth_page_passed;
        evt_in[GRP_AUTH][AUTH_ORIG_PASSED_BIT] = auth_orig_passed;
        evt_in[GRP_AUTH][AUTH_CHAL_PASSED_BIT] = auth_chal_passed;
        evt_in[GRP_AUTH][AUTH_UPD_PASSED_BIT] = auth_update_passed;
        evt_in[GRP_AUTH][AUTH_BURST_RESULT_BIT] =
            auth_burst_result;
        evt_in[GRP_SMS] = '0;
        evt_in[GRP_SMS][SMS_ACK_RECEIVED_BIT] = sms_ack_received;
    end

    for (genvar g = 0; g < NGRP; g++) begin : grp
        logic sel_me;
        logic wr_rise;
        logic wr_fall;
        logic wr_mask;
        logic rd_event;
        logic clr_event;
        logic [WIDTH-1:0] cond_mask;
        logic [WIDTH-1:0] only_mask;
        wire logic [WIDTH-1:0] rose;
        wire logic [WIDTH-1:0] fell;
        wire logic [WIDTH-1:0] edge_set;
        wire logic [WIDTH-1:0] pulse_set;
        wire logic [WIDTH-1:0] next_latch;
        wire logic [WIDTH-1:0] armed;

        // command decode for this group
        assign sel_me = (cmd.group == 1'(g));
        assign wr_rise = cmd.write && sel_me && cmd.sel == SEL_RISE_FILTER;
        assign wr_fall = cmd.write && sel_me && cmd.sel == SEL_FALL_FILTER;
        assign wr_mask = cmd.write && sel_me && cmd.sel == SEL_EVENT_MASK;
        assign rd_event = cmd.query && sel_me && cmd.sel == SEL_EVENT_LATCH;
        // query and clear-status share one clear path
        assign clr_event = rd_event || clear_status;

        // which bits have a live source and which only pulse
        assign cond_mask = (g == 0) ? AUTH_COND_MASK : SMS_COND_MASK;
        assign only_mask = (g == 0) ? AUTH_EVENT_ONLY_MASK
                                    : SMS_EVENT_ONLY_MASK;

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cond_q[g] <= '0;
            end else begin
                cond_q[g] <= cond[g];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                rise_filter[g] <= RISE_FILTER_RESET;
            end else if (wr_rise) begin
                rise_filter[g] <= cmd.data;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                fall_filter[g] <= FALL_FILTER_RESET;
            end else if (wr_fall) begin
                fall_filter[g] <= cmd.data;
            end
        end

        // writing zero clears every enable bit by the same path
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                event_mask[g] <= EVENT_MASK_RESET;
            end else if (wr_mask) begin
                event_mask[g] <= cmd.data;
            end
        end

        // per-bit edge qualification; bits with no source never fire
        for (genvar b = 0; b < WIDTH; b++) begin : bit_slot
            assign rose[b] = cond[g][b] && !cond_q[g][b];
            assign fell[b] = !cond[g][b] && cond_q[g][b];
            assign edge_set[b] = cond_mask[b] && (
                (rose[b] && rise_filter[g][b])
                || (fell[b] && fall_filter[g][b]));
            assign pulse_set[b] = only_mask[b] && evt_in[g][b];
            // a new event in the clearing cycle survives the clear
            assign next_latch[b] = edge_set[b] || pulse_set[b]
                || (event_latch[g][b] && !clr_event);
            assign armed[b] = event_latch[g][b] && event_mask[g][b];
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                event_latch[g] <= EVENT_LATCH_RESET;
            end else begin
                event_latch[g] <= next_latch;
            end
        end

        always_comb begin
            case (cmd.sel)
                SEL_CONDITION: read_mux[g] = cond[g];
                SEL_RISE_FILTER: read_mux[g] = rise_filter[g];
                SEL_FALL_FILTER: read_mux[g] = fall_filter[g];
                SEL_EVENT_LATCH: read_mux[g] = event_latch[g];
                SEL_EVENT_MASK: read_mux[g] = event_mask[g];
                default: read_mux[g] = '0;
            endcase
        end

        assign summary[g] = |armed;
    end

    // answer one cycle after the query; unknown selector reads zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp <= '0;
        end else if (cmd.query) begin
            resp.valid <= 1'b1;
            resp.data <= read_mux[cmd.group];
        end else begin
            resp.valid <= 1'b0;
            resp.data <= '0;
        end
    end

    // registered so the status byte path never sees a decode glitch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            auth_group_summary_bit <= 1'b0;
        end else begin
            auth_group_summary_bit <= summary[GRP_AUTH];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sms_group_summary_bit <= 1'b0;
        end else begin
            sms_group_summary_bit <= summary[GRP_SMS];
        end
    end

    // the general group is gated here, not by this bank's masks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_summary_to_status_byte <= 1'b0;
        end else begin
            general_summary_to_status_byte <=
                general_group_summary && general_summary_enable;
        end
    end
endmodule

// *** logic/cassr_pkg.sv ***
/*
 * Package for the authentication and short-message status register groups:
 * register selectors, bit positions, reset values and the command carrier.
 * Assumes one system clock and a command decoder that turns remote status
 * queries and writes into one-cycle command strobes.
 */
package cassr_pkg;
    localparam int unsigned REG_WIDTH = 16;

    // register selectors within a group
    localparam logic [2:0] SEL_CONDITION = 3'h0;
    localparam logic [2:0] SEL_RISE_FILTER = 3'h1;
    localparam logic [2:0] SEL_FALL_FILTER = 3'h2;
    localparam logic [2:0] SEL_EVENT_LATCH = 3'h3;
    localparam logic [2:0] SEL_EVENT_MASK = 3'h4;

    // group selectors
    localparam logic GRP_AUTH = 1'h0;
    localparam logic GRP_SMS = 1'h1;

    // authentication group bit positions
    localparam int unsigned AUTH_IN_PROGRESS_BIT = 0;
    localparam int unsigned AUTH_SECRET_UPDATE_BIT = 1;
    localparam int unsigned AUTH_CHALLENGE_BIT = 2;
    localparam int unsigned AUTH_SECRET_ZERO_BIT = 3;
    localparam int unsigned AUTH_REG_PASSED_BIT = 7;
    localparam int unsigned AUTH_PAGE_PASSED_BIT = 8;
    localparam int unsigned AUTH_ORIG_PASSED_BIT = 9;
    localparam int unsigned AUTH_CHAL_PASSED_BIT = 10;
    localparam int unsigned AUTH_UPD_PASSED_BIT = 11;
    localparam int unsigned AUTH_BURST_RESULT_BIT = 12;

    // short-message group bit positions
    localparam int unsigned SMS_IN_PROGRESS_BIT = 0;
    localparam int unsigned SMS_ACK_RECEIVED_BIT = 1;

    // bits backed by a condition source, and event-only bits, in each group
    localparam logic [15:0] AUTH_COND_MASK = 16'h000f;
    localparam logic [15:0] AUTH_EVENT_ONLY_MASK = 16'h1f80;
    localparam logic [15:0] SMS_COND_MASK = 16'h0001;
    localparam logic [15:0] SMS_EVENT_ONLY_MASK = 16'h0002;

    // reset values
    localparam logic [15:0] RISE_FILTER_RESET = 16'hffff;
    localparam logic [15:0] FALL_FILTER_RESET = 16'h0000;
    localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;
    localparam logic [15:0] EVENT_LATCH_RESET = 16'h0000;

    typedef struct packed {
        logic query;
        logic write;
        logic group;
        logic [2:0] sel;
        logic [15:0] data;
    } cassr_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } cassr_resp_t;
endpackage

// *** verif/cassr_regs_properties.sv ***
/*
 * Concurrent checks on the status register bank ports.
 * Bound into every cassr_regs instance; sees only the top ports.
 */
`timescale 1ns/1ps
module cassr_regs_props
    import cassr_pkg::*;
#(
    parameter int unsigned WIDTH = REG_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire cassr_cmd_t cmd,
    input wire logic clear_status,
    input wire logic shared_secret_a_value_zero,
    input wire logic auth_burst_result,
    input wire logic sms_in_progress,
    input wire logic sms_ack_received,
    input wire logic general_group_summary,
    input wire logic general_summary_enable,
    input wire cassr_resp_t resp,
    input wire logic general_summary_to_status_byte
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_answer; cmd.query |=> resp.valid; endproperty
    a_answer: assert property (p_answer)
        else $error("query got no answer");
    property p_auth_cond; cmd.query && cmd.group == GRP_AUTH
        && cmd.sel == SEL_CONDITION |=> resp.data[15:4] == 12'h0
        && resp.data[3] == $past(shared_secret_a_value_zero); endproperty
    a_auth_cond: assert property (p_auth_cond)
        else $error("auth condition read wrong");
    property p_sms_cond; cmd.query && cmd.group == GRP_SMS
        && cmd.sel == SEL_CONDITION
        |=> resp.data == {15'h0, $past(sms_in_progress)}; endproperty
    a_sms_cond: assert property (p_sms_cond)
        else $error("sms condition read wrong");
    property p_gen; 1'b1 |=> general_summary_to_status_byte ==
        ($past(general_summary_enable) && $past(general_group_summary));
    endproperty
    a_gen: assert property (p_gen)
        else $error("general summary gating wrong");
    property p_clr; clear_status && !sms_ack_received
        && $stable(sms_in_progress) ##1 cmd.query && cmd.group == GRP_SMS
        && cmd.sel == SEL_EVENT_LATCH && !sms_ack_received
        && $stable(sms_in_progress) |=> resp.data == 16'h0; endproperty
    a_clr: assert property (p_clr)
        else $error("clear status left events");
    property p_ack; sms_ack_received ##1 cmd.query && cmd.group == GRP_SMS
        && cmd.sel == SEL_EVENT_LATCH |=> resp.data[1]; endproperty
    a_ack: assert property (p_ack)
        else $error("ack event not latched");
    property p_burst; auth_burst_result ##1 cmd.query
        && cmd.group == GRP_AUTH && cmd.sel == SEL_EVENT_LATCH
        |=> resp.data[12]; endproperty
    a_burst: assert property (p_burst)
        else $error("burst result not latched");
    property p_mask; cmd.write && cmd.sel == SEL_EVENT_MASK ##1 !cmd.write
        ##1 cmd.query && !cmd.write && cmd.sel == SEL_EVENT_MASK
        && cmd.group == $past(cmd.group, 2)
        |=> resp.data == $past(cmd.data, 3); endproperty
    a_mask: assert property (p_mask)
        else $error("enable mask readback wrong");
endmodule
bind cassr_regs cassr_regs_props #(.WIDTH(WIDTH)) u_cassr_regs_props (
    .ref_clk, .rst, .cmd, .clear_status, .shared_secret_a_value_zero,
    .auth_burst_result, .sms_in_progress, .sms_ack_received,
    .general_group_summary, .general_summary_enable, .resp,
    .general_summary_to_status_byte);

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for the status register bank.
 * Assumes the package and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import cassr_pkg::*;
    logic ref_clk = 0, rst = 1, clear_status = 0, sms_in_progress = 0;
    logic sms_ack_received = 0, gsum = 0, gen = 0, asum, ssum, gout;
    logic [3:0] ac = 4'h0;
    logic [5:0] ap = 6'h0;
    logic [15:0] d, v, p, c, rf, ff, e;
    logic [15:0] rv [6] = '{16'h0, RISE_FILTER_RESET, FALL_FILTER_RESET,
        EVENT_LATCH_RESET, EVENT_MASK_RESET, 16'h0};
    cassr_cmd_t cmd = '0;
    cassr_resp_t resp;
    int n_mismatch = 0, samples_checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    cassr_regs u_cassr_regs (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
        .clear_status(clear_status), .auth_in_progress(ac[0]),
        .auth_secret_update_busy(ac[1]), .auth_challenge_busy(ac[2]),
        .shared_secret_a_value_zero(ac[3]), .auth_reg_passed(ap[0]),
        .auth_page_passed(ap[1]), .auth_orig_passed(ap[2]),
        .auth_chal_passed(ap[3]), .auth_update_passed(ap[4]),
        .auth_burst_result(ap[5]), .sms_in_progress(sms_in_progress),
        .sms_ack_received(sms_ack_received), .general_group_summary(gsum),
        .general_summary_enable(gen), .resp(resp),
        .auth_group_summary_bit(asum), .sms_group_summary_bit(ssum),
        .general_summary_to_status_byte(gout));
    task automatic chk(string n, logic [15:0] x, logic [15:0] y);
        samples_checked++;
        if (y !== x) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // idle cycle after each command keeps cmd single-assigned per step
    task automatic op(logic q, w, g, logic [2:0] s, logic [15:0] x);
        cmd = '{q, w, g, s, x};
        tick();
        cmd = '0;
        d = resp.data;
        if (q) chk("valid", 16'h1, {15'h0, resp.valid});
        tick();
    endtask
    task automatic fire();
        ap = 6'h3f;
        sms_ack_received = 1;
        tick();
        ap = 6'h0;
        sms_ack_received = 0;
    endtask
    function automatic logic [15:0] edge_exp(logic [15:0] a, b, r, f, m);
        return ((~a & b & r) | (a & ~b & f)) & m;
    endfunction
    task automatic summarize();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(25 * 3000);
        n_mismatch++;
        summarize();
    end
    initial begin
        void'($urandom(59));
        tick(6);
        rst = 0;
        tick();
        for (int g = 0; g < 2; g++) begin
            for (int s = 0; s < 6; s++) begin
                v = $urandom;
                op(1, 1, g[0], s[2:0], v);
                chk("old", rv[s], d);
                e = (s inside {1, 2, 4}) ? v : 16'h0;
                op(1, 0, g[0], s[2:0], 16'h0);
                chk("back", e, d);
            end
            op(0, 1, g[0], SEL_EVENT_MASK, 16'h0);
            op(1, 0, g[0], SEL_EVENT_MASK, 16'h0);
            chk("zero", 16'h0, d);
        end
        repeat (8) begin
            rf = $urandom;
            ff = $urandom;
            for (int g = 0; g < 2; g++) begin
                op(0, 1, g[0], SEL_RISE_FILTER, rf);
                op(0, 1, g[0], SEL_FALL_FILTER, ff);
            end
            p = $urandom;
            {sms_in_progress, ac} = p[4:0];
            tick(2);
            op(1, 0, 0, SEL_EVENT_LATCH, 16'h0);
            op(1, 0, 1, SEL_EVENT_LATCH, 16'h0);
            c = $urandom;
            {sms_in_progress, ac} = c[4:0];
            op(1, 0, 0, SEL_CONDITION, 16'h0);
            chk("acond", c & 16'hf, d);
            op(1, 0, 1, SEL_CONDITION, 16'h0);
            chk("scond", {15'h0, c[4]}, d);
            e = edge_exp(p, c, rf, ff, AUTH_COND_MASK);
            op(1, 0, 0, SEL_EVENT_LATCH, 16'h0);
            chk("aedge", e, d);
            e = edge_exp(p >> 4, c >> 4, rf, ff, SMS_COND_MASK);
            op(1, 0, 1, SEL_EVENT_LATCH, 16'h0);
            chk("sedge", e, d);
        end
        fire();
        op(1, 0, 0, SEL_EVENT_LATCH, 16'h0);
        chk("aonly", 16'h1f80, d);
        fire();
        op(1, 0, 1, SEL_EVENT_LATCH, 16'h0);
        chk("sonly", 16'h0002, d);
        op(0, 1, 0, SEL_EVENT_MASK, 16'h1000);
        op(0, 1, 1, SEL_EVENT_MASK, 16'h0002);
        fire();
        tick(2);
        chk("sums", 16'h3, {14'h0, ssum, asum});
        clear_status = 1;
        tick();
        clear_status = 0;
        op(1, 0, 1, SEL_EVENT_LATCH, 16'h0);
        chk("sclr", 16'h0, d);
        op(1, 0, 0, SEL_EVENT_LATCH, 16'h0);
        chk("aclr", 16'h0, d);
        chk("sums", 16'h0, {14'h0, ssum, asum});
        for (int i = 0; i < 4; i++) begin
            {gsum, gen} = i[1:0];
            tick(2);
            chk("gen", {15'h0, i == 3}, {15'h0, gout});
        end
        summarize();
    end
endmodule
